//--- mxbbe_pkg.sv
// Purpose: constants for the transfer, table-read and bit-processor executor
// Assumes: classic 8-bit core opcode encodings, bit address in instruction
// Notes: one memory access per state, pc points past current instruction
// Behaviour
// - external moves use r0/r1 or data pointer
// - accumulator is sole external data source/sink
// - table read at data pointer plus accumulator
// - pc-based table uses next-instruction pc base
// - lookup instructions never write program memory
// - bits 00h-7Fh ram, 80h-FFh special space
// - operand bit given by direct address only
// - carry is bit accumulator, also bit-addressable
// - and/or, notted forms, move, clear, set, complement
// - jumps on carry or bit, else fall through
// - test-and-clear jump clears bit when taken
// - taken jump adds signed offset to pc
// - range -128..+127 from following instruction
// - every port line individually bit-addressable
// - every status word bit bit-addressable
// - nibble exchange swaps only low nibbles
// - external move three cycles, third has no fetch
package mxbbe_pkg;
    localparam logic [7:0] OP_XRD_R   = 8'hE2; // e2/e3
    localparam logic [7:0] OP_XWR_R   = 8'hF2; // f2/f3
    localparam logic [7:0] OP_XRD_DP  = 8'hE0;
    localparam logic [7:0] OP_XWR_DP  = 8'hF0;
    localparam logic [7:0] OP_TBL_DP  = 8'h93;
    localparam logic [7:0] OP_TBL_PC  = 8'h83;
    localparam logic [7:0] OP_NIBX    = 8'hD6; // d6/d7
    localparam logic [7:0] OP_ANL_B   = 8'h82;
    localparam logic [7:0] OP_ANL_NB  = 8'hB0;
    localparam logic [7:0] OP_ORL_B   = 8'h72;
    localparam logic [7:0] OP_ORL_NB  = 8'hA0;
    localparam logic [7:0] OP_MOV_CB  = 8'hA2;
    localparam logic [7:0] OP_MOV_BC  = 8'h92;
    localparam logic [7:0] OP_CLR_C   = 8'hC3;
    localparam logic [7:0] OP_CLR_B   = 8'hC2;
    localparam logic [7:0] OP_SET_C   = 8'hD3;
    localparam logic [7:0] OP_SET_B   = 8'hD2;
    localparam logic [7:0] OP_INV_C   = 8'hB3;
    localparam logic [7:0] OP_INV_B   = 8'hB2;
    localparam logic [7:0] OP_JMP_CS  = 8'h40;
    localparam logic [7:0] OP_JMP_CC  = 8'h50;
    localparam logic [7:0] OP_JMP_BS  = 8'h20;
    localparam logic [7:0] OP_JMP_BC  = 8'h30;
    localparam logic [7:0] OP_JMP_BSC = 8'h10;
    localparam int         CARRY_POS  = 7;
    localparam logic [7:0] STATUS_BYTE = 8'hD0;
    localparam logic [7:0] CARRY_BIT  = 8'hD7;
    localparam logic [7:0] RAM_BIT_BASE = 8'h20;
    localparam logic [15:0] PC_RESET  = 16'h0000;
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [15:0] DP_RESET  = 16'h0000;

    typedef enum logic [3:0] {
        ST_FETCH = 4'h0,
        ST_DEC   = 4'h1,
        ST_OPA   = 4'h2,
        ST_OPB   = 4'h3,
        ST_BRD   = 4'h4,
        ST_BWR   = 4'h5,
        ST_XCY2  = 4'h6,
        ST_TBL   = 4'h7,
        ST_IRD   = 4'h8,
        ST_NIB   = 4'h9
    } mxbbe_state_t;
endpackage : mxbbe_pkg

//--- mxbbe_core.sv
// Purpose: executes transfer, table-read, nibble and bit-processor opcodes
// Assumes: memories answer combinationally in the cycle of the request
// Notes: other opcodes are skipped as one-byte no-ops
`timescale 1ns/1ps
module mxbbe_core
    import mxbbe_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic [1:0]  BANK_I,
    output logic [15:0] CODE_ADDR_O,
    output logic        CODE_RD_O,
    input  wire logic [7:0]  CODE_DATA_I,
    output logic [15:0] XDATA_ADDR_O,
    output logic        XDATA_RD_O,
    output logic        XDATA_WR_O,
    output logic [7:0]  XDATA_WDATA_O,
    input  wire logic [7:0]  XDATA_RDATA_I,
    output logic [7:0]  IRAM_ADDR_O,
    output logic        IRAM_WR_O,
    output logic [7:0]  IRAM_WDATA_O,
    input  wire logic [7:0]  IRAM_RDATA_I,
    output logic [15:0] PC_O,
    output logic [7:0]  ACC_O,
    output logic [15:0] DATA_POINTER_O,
    output logic [7:0]  PROGRAM_STATUS_WORD_O
);

    typedef struct packed {
        mxbbe_state_t st;
        logic [15:0]  pc;
        logic [7:0]   acc;
        logic [15:0]  dp;
        logic [7:0]   stat;
        logic [7:0]   op;
        logic [7:0]   badr;
        logic [7:0]   rel;
        logic [7:0]   ptr;
        logic [7:0]   byt;
    } mxbbe_s_t;

    mxbbe_s_t s_reg;
    mxbbe_s_t s_next;

    ////////////////////////////////////////////////////////////////////
    function automatic logic is_bitop(input logic [7:0] o);
        is_bitop = (o == OP_ANL_B) || (o == OP_ANL_NB) || (o == OP_ORL_B)
                || (o == OP_ORL_NB) || (o == OP_MOV_CB)
                || (o == OP_MOV_BC) || (o == OP_CLR_B) || (o == OP_SET_B)
                || (o == OP_INV_B) || (o == OP_JMP_BS) || (o == OP_JMP_BC)
                || (o == OP_JMP_BSC);
    endfunction : is_bitop

    // byte holding a bit: ram page from 20h or 8-aligned special byte
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        if (b[7])
            bit_byte = {b[7:3], 3'b000};
        else
            bit_byte = RAM_BIT_BASE + {4'h0, b[6:3]};
    endfunction : bit_byte

    ////////////////////////////////////////////////////////////////////
    logic [15:0] seq_pc;
    logic        cy;
    logic        bv;
    logic        taken;
    logic [7:0]  nb;

    always_comb
    begin
        s_next         = s_reg;
        seq_pc         = s_reg.pc + 16'h0001;
        cy             = s_reg.stat[CARRY_POS];
        bv             = s_reg.byt[s_reg.badr[2:0]];
        taken          = 1'b0;
        nb             = s_reg.byt;
        CODE_ADDR_O    = s_reg.pc;
        CODE_RD_O      = 1'b0;
        XDATA_ADDR_O   = s_reg.dp;
        XDATA_RD_O     = 1'b0;
        XDATA_WR_O     = 1'b0;
        IRAM_ADDR_O    = s_reg.ptr;
        IRAM_WR_O      = 1'b0;
        IRAM_WDATA_O   = s_reg.byt;
        case (s_reg.st)
            ST_FETCH:
            begin
                CODE_RD_O = 1'b1;
                s_next.op = CODE_DATA_I;
                s_next.pc = seq_pc;
                s_next.st = ST_DEC;
            end
            ST_DEC:
            begin
                s_next.st = ST_FETCH;
                if ({s_reg.op[7:1], 1'b0} == OP_XRD_R
                    || {s_reg.op[7:1], 1'b0} == OP_XWR_R
                    || {s_reg.op[7:1], 1'b0} == OP_NIBX)
                begin
                    // indirect pointer reg r0/r1 of selected bank
                    IRAM_ADDR_O = {3'b000, BANK_I, 2'b00, s_reg.op[0]};
                    s_next.ptr  = IRAM_RDATA_I;
                    s_next.st   = ({s_reg.op[7:1], 1'b0} == OP_NIBX)
                                ? ST_IRD : ST_XCY2;
                end
                else if (s_reg.op == OP_XRD_DP || s_reg.op == OP_XWR_DP)
                    s_next.st = ST_XCY2;
                else if (s_reg.op == OP_TBL_DP || s_reg.op == OP_TBL_PC)
                    s_next.st = ST_TBL;
                else if (s_reg.op == OP_CLR_C)
                    s_next.stat[CARRY_POS] = 1'b0;
                else if (s_reg.op == OP_SET_C)
                    s_next.stat[CARRY_POS] = 1'b1;
                else if (s_reg.op == OP_INV_C)
                    s_next.stat[CARRY_POS] = ~cy;
                else if (s_reg.op == OP_JMP_CS || s_reg.op == OP_JMP_CC)
                    s_next.st = ST_OPB;
                else if (is_bitop(s_reg.op))
                    s_next.st = ST_OPA;
            end
            ST_OPA:
            begin
                CODE_RD_O   = 1'b1;
                s_next.badr = CODE_DATA_I;
                s_next.pc   = seq_pc;
                s_next.st   = (s_reg.op == OP_JMP_BS || s_reg.op == OP_JMP_BC
                              || s_reg.op == OP_JMP_BSC) ? ST_OPB : ST_BRD;
            end
            ST_OPB:
            begin
                CODE_RD_O  = 1'b1;
                s_next.rel = CODE_DATA_I;
                s_next.pc  = seq_pc;
                s_next.st  = (s_reg.op == OP_JMP_CS || s_reg.op == OP_JMP_CC)
                           ? ST_BWR : ST_BRD;
            end
            ST_BRD:
            begin
                // status word is held here, so read it locally
                IRAM_ADDR_O = bit_byte(s_reg.badr);
                s_next.byt  = (bit_byte(s_reg.badr) == STATUS_BYTE)
                            ? s_reg.stat : IRAM_RDATA_I;
                s_next.st   = ST_BWR;
            end
            ST_BWR:
            begin
                s_next.st   = ST_FETCH;
                IRAM_ADDR_O = bit_byte(s_reg.badr);
                case (s_reg.op)
                    OP_ANL_B:  s_next.stat[CARRY_POS] = cy & bv;
                    OP_ANL_NB: s_next.stat[CARRY_POS] = cy & ~bv;
                    OP_ORL_B:  s_next.stat[CARRY_POS] = cy | bv;
                    OP_ORL_NB: s_next.stat[CARRY_POS] = cy | ~bv;
                    OP_MOV_CB: s_next.stat[CARRY_POS] = bv;
                    OP_MOV_BC: nb[s_reg.badr[2:0]] = cy;
                    OP_CLR_B:  nb[s_reg.badr[2:0]] = 1'b0;
                    OP_SET_B:  nb[s_reg.badr[2:0]] = 1'b1;
                    OP_INV_B:  nb[s_reg.badr[2:0]] = ~bv;
                    OP_JMP_CS: taken = cy;
                    OP_JMP_CC: taken = ~cy;
                    OP_JMP_BS: taken = bv;
                    OP_JMP_BC: taken = ~bv;
                    OP_JMP_BSC:
                    begin
                        taken = bv;
                        if (bv)
                            nb[s_reg.badr[2:0]] = 1'b0;
                    end
                    default: taken = 1'b0;
                endcase
                if (nb != s_reg.byt)
                begin
                    if (bit_byte(s_reg.badr) == STATUS_BYTE)
                        s_next.stat = nb;
                    else
                        IRAM_WR_O = 1'b1;
                    IRAM_WDATA_O = nb;
                end
                if (taken)
                    s_next.pc = s_reg.pc
                              + {{8{s_reg.rel[7]}}, s_reg.rel};
            end
            ST_XCY2:
            begin
                // third cycle: no code fetch
                // opcode bit 1 picks the 8-bit pointer form
                XDATA_ADDR_O = s_reg.op[1] ? {8'h00, s_reg.ptr}
                                           : s_reg.dp;
                XDATA_RD_O   = (s_reg.op[7:4] == 4'hE);
                XDATA_WR_O   = (s_reg.op[7:4] == 4'hF);
                if (s_reg.op[7:4] == 4'hE)
                    s_next.acc = XDATA_RDATA_I;
                s_next.st = ST_FETCH;
            end
            ST_TBL:
            begin
                CODE_RD_O   = 1'b1;
                CODE_ADDR_O = (s_reg.op == OP_TBL_DP ? s_reg.dp : s_reg.pc)
                            + {8'h00, s_reg.acc};
                s_next.acc  = CODE_DATA_I;
                s_next.st   = ST_FETCH;
            end
            ST_IRD:
            begin
                s_next.byt = IRAM_RDATA_I;
                s_next.st  = ST_NIB;
            end
            ST_NIB:
            begin
                IRAM_WR_O    = 1'b1;
                IRAM_WDATA_O = {s_reg.byt[7:4], s_reg.acc[3:0]};
                s_next.acc   = {s_reg.acc[7:4], s_reg.byt[3:0]};
                s_next.st    = ST_FETCH;
            end
            default: s_next.st = ST_FETCH;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            s_reg     <= '0;
            s_reg.st  <= ST_FETCH;
            s_reg.pc  <= PC_RESET;
            s_reg.acc <= ACC_RESET;
            s_reg.dp  <= DP_RESET;
        end
        else
            s_reg <= s_next;
    end

    assign XDATA_WDATA_O         = s_reg.acc;
    assign PC_O                  = s_reg.pc;
    assign ACC_O                 = s_reg.acc;
    assign DATA_POINTER_O        = s_reg.dp;
    assign PROGRAM_STATUS_WORD_O = s_reg.stat;

endmodule : mxbbe_core

//--- mxbbe_mem.sv
// Purpose: program, external data and internal ram model
// Assumes: combinational reads, writes on the rising edge
// Notes: idle code and external read data is inverted, never a held byte; internal ram reads are never gated
`timescale 1ns/1ps
module mxbbe_mem
(
    input  wire logic        CLK_I,
    input  wire logic [15:0] CODE_ADDR_O,
    input  wire logic        CODE_RD_O,
    output logic [7:0]       CODE_DATA_I,
    input  wire logic [15:0] XDATA_ADDR_O,
    input  wire logic        XDATA_RD_O,
    input  wire logic        XDATA_WR_O,
    input  wire logic [7:0]  XDATA_WDATA_O,
    output logic [7:0]       XDATA_RDATA_I,
    input  wire logic [7:0]  IRAM_ADDR_O,
    input  wire logic        IRAM_WR_O,
    input  wire logic [7:0]  IRAM_WDATA_O,
    output logic [7:0]       IRAM_RDATA_I
);
    logic [7:0] code [256];
    logic [7:0] xram [256];
    logic [7:0] iram [256];
    ////////////////////////////////////////
    assign CODE_DATA_I   = CODE_RD_O ? code[CODE_ADDR_O[7:0]]
                                     : ~code[CODE_ADDR_O[7:0]];
    assign XDATA_RDATA_I = XDATA_RD_O ? xram[XDATA_ADDR_O[7:0]]
                                      : ~xram[XDATA_ADDR_O[7:0]];
    assign IRAM_RDATA_I  = iram[IRAM_ADDR_O];
    always @(posedge CLK_I)
    begin
        if (XDATA_WR_O)
            xram[XDATA_ADDR_O[7:0]] <= XDATA_WDATA_O;
        if (IRAM_WR_O)
            iram[IRAM_ADDR_O] <= IRAM_WDATA_O;
    end
endmodule : mxbbe_mem

//--- mxbbe_sva.sv
// Purpose: port checks for the executor
// Assumes: opcodes seen on code reads
// Notes: bound to mxbbe_core
`timescale 1ns/1ps
module mxbbe_sva
    import mxbbe_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic [15:0] CODE_ADDR_O,
    input wire logic        CODE_RD_O,
    input wire logic [7:0]  CODE_DATA_I,
    input wire logic [15:0] XDATA_ADDR_O,
    input wire logic        XDATA_RD_O,
    input wire logic        XDATA_WR_O,
    input wire logic [7:0]  XDATA_WDATA_O,
    input wire logic [7:0]  XDATA_RDATA_I,
    input wire logic [7:0]  IRAM_ADDR_O,
    input wire logic        IRAM_WR_O,
    input wire logic [7:0]  IRAM_WDATA_O,
    input wire logic [7:0]  IRAM_RDATA_I,
    input wire logic [7:0]  ACC_O,
    input wire logic [15:0] DATA_POINTER_O,
    input wire logic [7:0]  PROGRAM_STATUS_WORD_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire xs = XDATA_RD_O | XDATA_WR_O;
    wire cy = PROGRAM_STATUS_WORD_O[CARRY_POS];
    // code and ram bytes of the last few cycles
    logic [7:0] code_d1;
    logic [7:0] code_d2;
    logic [7:0] code_d3;
    logic [7:0] iram_d1;
    always_ff @(posedge CLK_I)
    begin
        code_d1 <= CODE_DATA_I;
        code_d2 <= code_d1;
        code_d3 <= code_d2;
        iram_d1 <= IRAM_RDATA_I;
    end
    wire       tclr_hit  = !code_d3[7] && iram_d1[code_d3[2:0]];
    wire [7:0] tclr_byte = RAM_BIT_BASE + {4'h0, code_d3[6:3]};
    ////////////////////////////////////////
    property p_nofetch; xs |-> !CODE_RD_O ##1 (CODE_RD_O && !xs); endproperty
    a_nofetch: assert property (p_nofetch)
        else $error("fetch beside external move");
    property p_wacc; XDATA_WR_O |-> XDATA_WDATA_O == ACC_O; endproperty
    a_wacc: assert property (p_wacc)
        else $error("write data not accumulator");
    property p_racc; XDATA_RD_O |=> ACC_O == $past(XDATA_RDATA_I); endproperty
    a_racc: assert property (p_racc)
        else $error("read data not in accumulator");
    property p_xadr;
        xs |-> (code_d2[1] ? XDATA_ADDR_O == {8'h00, iram_d1}
                           : XDATA_ADDR_O == DATA_POINTER_O);
    endproperty
    a_xadr: assert property (p_xadr)
        else $error("external address not pointer");
    property p_tdp;
        CODE_RD_O && CODE_DATA_I == OP_TBL_DP ##2 CODE_RD_O
        |-> CODE_ADDR_O == DATA_POINTER_O + {8'h00, ACC_O}
            ##1 ACC_O == $past(CODE_DATA_I);
    endproperty
    a_tdp: assert property (p_tdp)
        else $error("pointer table read wrong");
    property p_tpc;
        CODE_RD_O && CODE_DATA_I == OP_TBL_PC ##2 1'b1
        |-> CODE_ADDR_O == $past(CODE_ADDR_O, 2) + 16'h0001
                           + {8'h00, ACC_O};
    endproperty
    a_tpc: assert property (p_tpc)
        else $error("pc table base wrong");
    property p_jmp;
        CODE_RD_O && CODE_DATA_I == OP_JMP_CC && !cy ##4 1'b1
        |-> CODE_ADDR_O == $past(CODE_ADDR_O, 4) + 16'h0002
                           + {{8{code_d2[7]}}, code_d2};
    endproperty
    a_jmp: assert property (p_jmp)
        else $error("relative target wrong");
    property p_fall;
        CODE_RD_O && CODE_DATA_I == OP_JMP_CC && cy ##4 1'b1
        |-> CODE_RD_O && CODE_ADDR_O == $past(CODE_ADDR_O, 4) + 16'h0002;
    endproperty
    a_fall: assert property (p_fall)
        else $error("untaken jump not at next");
    property p_tclr;
        CODE_RD_O && CODE_DATA_I == OP_JMP_BSC ##5 tclr_hit
        |-> IRAM_WR_O && IRAM_ADDR_O == tclr_byte
            && !IRAM_WDATA_O[code_d3[2:0]];
    endproperty
    a_tclr: assert property (p_tclr)
        else $error("tested bit not cleared");
    c_xwr: cover property (XDATA_WR_O);
    c_iwr: cover property (IRAM_WR_O);
    c_tpc: cover property (CODE_RD_O && CODE_DATA_I == OP_TBL_PC);
endmodule : mxbbe_sva

bind mxbbe_core mxbbe_sva u_sva (.*);

//--- test_mcu_xfer_bool_branch_exec.sv
// Purpose: runs one program through executor and memories
// Assumes: bank 1 selected, memories preset before reset
// Notes: state checked once pc passes the last jump
`timescale 1ns/1ps
module test_mcu_xfer_bool_branch_exec;
    logic        CLK_I = 1'b0;
    logic        RST_I = 1'b1;
    logic [1:0]  BANK_I = 2'h1;
    logic [15:0] CODE_ADDR_O, XDATA_ADDR_O, PC_O, DATA_POINTER_O;
    logic [7:0]  CODE_DATA_I, XDATA_WDATA_O, XDATA_RDATA_I, IRAM_ADDR_O;
    logic [7:0]  IRAM_WDATA_O, IRAM_RDATA_I, ACC_O, PROGRAM_STATUS_WORD_O;
    logic        CODE_RD_O, XDATA_RD_O, XDATA_WR_O, IRAM_WR_O;
    int          mismatches = 0;
    int          checked = 0;
    localparam logic [495:0] PRG = {
        256'hE3F2E0F39383D6D3922FB2D68228B028A020C37228C22FB3A228D290B2214002,
        240'hC30050FE202802C3003028F0102103C300001021804004D3400900B350F9};
    always #4 CLK_I = ~CLK_I;
    mxbbe_core dut (.*);
    mxbbe_mem mem (.*);
    ////////////////////////////////////////
    task automatic end_of_test;
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // program needs about 130 cycles
    initial
    begin
        #20000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            mem.code[i] = (i < 62) ? PRG[495-8*i -: 8] : 8'h00;
            mem.xram[i] = 8'h00;
            mem.iram[i] = 8'h00;
        end
        mem.code[8'hA7] = 8'hEA;
        mem.code[8'hF0] = 8'h77;
        mem.xram[8'h41] = 8'h3C;
        mem.xram[8'h00] = 8'hA7;
        mem.iram[8'h08] = 8'h40;
        mem.iram[8'h09] = 8'h41;
        mem.iram[8'h40] = 8'h96;
        mem.iram[8'h25] = 8'h01;
        repeat (6) @(negedge CLK_I);
        chk({ACC_O, PROGRAM_STATUS_WORD_O}, 16'h0000);
        RST_I = 1'b0;
        while (PC_O !== 16'h0045) @(negedge CLK_I);
        chk({8'h00, ACC_O}, 16'h0076);
        chk({8'h00, PROGRAM_STATUS_WORD_O & 8'hFE}, 16'h00C0);
        chk({mem.xram[8'h40], mem.xram[8'h41]}, 16'h3CA7);
        chk({8'h00, mem.xram[8'h00]}, 16'h00A7);
        chk({mem.iram[8'h40], mem.iram[8'h25]}, 16'h9701);
        chk({mem.iram[8'h24], mem.iram[8'h90]}, 16'h0001);
        chk(DATA_POINTER_O, 16'h0000);
        end_of_test();
    end
endmodule : test_mcu_xfer_bool_branch_exec
